// ==== src/gs_defs.svh ====
// Named constants of the gas sensor output block.
// Assumes a 250 MHz core clock; included by the top module.
`ifndef GS_DEFS_SVH
`define GS_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define GS_CLK_HZ        250000000
`define GS_MS_HZ         1000
`define GS_BAUD_HZ       38400
`define GS_REFRESH_MS    5000
`define GS_CAL_MIN_MIN   10
`define GS_CAL_MIN_MS    (`GS_CAL_MIN_MIN * 60 * 1000)

// ----------------------------------------------------------------------------
// PWM and alarm
// ----------------------------------------------------------------------------
`define GS_PWM_START_MS  2
`define GS_PWM_SPAN_MS   1000
`define GS_PWM_PERIOD_MS 11'd2000
`define GS_RANGE_DEF     2000
`define GS_ALARM_ON_PPM  16'd1200
`define GS_ALARM_OFF_PPM 16'd800

// ----------------------------------------------------------------------------
// Serial and two-wire encodings
// ----------------------------------------------------------------------------
`define GS_BITS          4'h8
`define GS_TX_BITS       4'h9
`define GS_RX_STOP       4'ha
`define GS_I2C_ADDR      7'h31
`define GS_CMD_READ      8'h52
`define GS_CMD_CAL_GO    8'h4d
`define GS_CMD_CAL_STOP  8'h41
`define GS_RD_LAST       3'h6
`define GS_RES_BYTE      8'h00
`define GS_RPT_LAST      4'hb
`define GS_CH_SP         8'h20
`define GS_CH_ZERO       8'h30
`define GS_CH_P          8'h70
`define GS_CH_M          8'h6d
`define GS_CH_CR         8'h0d
`define GS_CH_LF         8'h0a

`endif

// ==== src/gs_pkg.sv ====
// Types shared by the gas sensor output block.
// Assumes gs_defs.svh is on the include path.
package gs_pkg;
  typedef enum logic [1:0] {I_IDLE, I_ADDR, I_WDATA, I_RDATA} gs_i2c_st_t;

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            wp;
    logic            rp;
    logic [1:0]      cnt;
  } gs_buf_t;

  typedef struct packed {
    logic [17:0] div;    logic        ms;     logic [12:0] rfr_ms; logic        rfr;
    logic [15:0] val;    logic        alarm;  logic [10:0] pms;    logic [10:0] th;
    logic        pwm;    logic        man;    logic        auto;   logic [19:0] cal_ms;
    logic        stop_pend; logic     cal_pin_q; logic     rp_act; logic [3:0]  rp_idx;
    logic        tx_busy; logic [8:0] tx_sh;  logic [3:0]  tx_bits; logic [12:0] tx_cnt;
    logic        txd;    logic [3:0]  rx_bit; logic [12:0] rx_cnt; logic [7:0]  rx_sh;
    gs_i2c_st_t  ist;    logic [3:0]  icnt;   logic [7:0]  ish;    logic        iack;
    logic        ird;    logic        ioe;    logic [2:0]  iidx;   logic [15:0] ival;
    logic        scl_q;  logic        sda_q;  logic        sdo;
  } gs_state_t;
endpackage

// ==== src/gs_buf2.sv ====
// Two-entry byte buffer with valid/ready on both sides.
// Assumes the clock and reset of the top module.
`timescale 1ns/1ps
`default_nettype none

module gs_buf2
  import gs_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // Filling side.
  input  wire logic       in_valid_i,
  input  wire logic [7:0] in_data_i,
  output logic            in_ready_o,
  // Draining side.
  output logic            out_valid_o,
  output logic [7:0]      out_data_o,
  input  wire logic       out_ready_i
);
  gs_buf_t b_r;
  gs_buf_t b_nxt;
  logic    push;
  logic    pop;

  // ---------------------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------------------
  // Full and empty follow the entry count, so a stalled reader fills it.
  assign in_ready_o  = (b_r.cnt != 2'h2);
  assign out_valid_o = (b_r.cnt != 2'h0);
  assign out_data_o  = b_r.mem[b_r.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update.
  always_comb
  begin
    b_nxt = b_r;
    if (push)
    begin
      b_nxt.mem[b_r.wp] = in_data_i;
      b_nxt.wp          = ~b_r.wp;
    end
    if (pop)
      b_nxt.rp = ~b_r.rp;
    if (push && !pop)
      b_nxt.cnt = b_r.cnt + 2'h1;
    else if (pop && !push)
      b_nxt.cnt = b_r.cnt - 2'h1;
  end

  // State register.
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      b_r <= '0;
    else
      b_r <= b_nxt;
  end
endmodule // gs_buf2

`default_nettype wire

// ==== src/gs_sensor_out.sv ====
// Output logic of a gas sensor: serial report, two-wire target, PWM, alarm
// and calibration mode control.
// Assumes one 250 MHz clock, all pins already synchronous to it, and a
// measurement value presented on conc_i by the measuring core.
//
// Functional notes
// [R1] Serial link is 38400 baud, 8 data bits, no parity, 1 stop bit.
// [R2] Report is six digits, space, p p m, CR, LF: twelve bytes.
// [R3] Leading zero digits are sent as spaces.
// [R4] Two-wire target only, answering address 0x31.
// [R5] Address byte is 0x63 for read and 0x62 for write.
// [R6] Host writes 0x52, stops, then reads seven bytes with acks.
// [R7] Host waits at least 1 ms before reading each byte.
// [R8] Read frame: config byte, two value bytes, four zero bytes.
// [R9] PWM high time is 2 ms plus 1000 ms times value over range.
// [R10] PWM period is 2000 ms; low time is the rest.
// [R11] PWM range defaults to 2000 ppm; 5000 ppm is a build option.
// [R12] Alarm sets at 1200 ppm or more, clears at 800 or less.
// [R13] Automatic calibration after power-up and whenever manual is off.
// [R14] Manual calibration lasts at least 10 minutes; host stops before 18.
// [R15] Manual calibration starts by serial, two-wire command or pin.
// [R16] Reported value refreshes on all outputs every five seconds.
// [R17] Value bytes are unsigned ppm, most significant first.
// [R18] One serial report is sent per value refresh.
`timescale 1ns/1ps
`default_nettype none
`include "gs_defs.svh"

module gs_sensor_out
  import gs_pkg::*;
#(
  parameter int unsigned MS_CYC     = `GS_CLK_HZ / `GS_MS_HZ,
  parameter int unsigned BAUD_CYC   = `GS_CLK_HZ / `GS_BAUD_HZ,
  parameter int unsigned REFRESH_MS = `GS_REFRESH_MS,
  parameter int unsigned CAL_MS     = `GS_CAL_MIN_MS,
  parameter int unsigned PWM_RANGE  = `GS_RANGE_DEF
)
(
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Measurement and calibration pin.
  input  wire logic [15:0] conc_i,
  input  wire logic        cal_pin_i,
  // Serial link.
  input  wire logic        rxd_i,
  output logic             uart_tx_o,
  // Two-wire target.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Indicators.
  output logic             pwm_o,
  output logic             alarm_o,
  output logic             auto_baseline_calibration_o,
  output logic             manual_timed_calibration_o
);
  localparam int unsigned HALF_CYC = BAUD_CYC / 2;

  gs_state_t  s_r;
  gs_state_t  n;
  logic       b_in_ready;
  logic       b_valid;
  logic [7:0] b_data;
  logic       b_pop;
  logic [7:0] rpt_byte;
  logic [7:0] dig [6];
  logic [10:0] th_calc;

  // ---------------------------------------------------------------------------
  // Report text
  // ---------------------------------------------------------------------------
  // Each decimal digit becomes a character; leading zeros become spaces.
  for (genvar k = 0; k < 6; k++)
  begin : g_dig
    localparam int unsigned P = 10 ** k;
    assign dig[k] = (k > 0 && 32'(s_r.val) < P) ? `GS_CH_SP : // R3
                    `GS_CH_ZERO + 8'((32'(s_r.val) / P) % 10);
  end

  // Byte of the twelve-byte report at the current index.
  always_comb
  begin
    unique case (s_r.rp_idx) // R2
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: rpt_byte = dig[3'(5 - s_r.rp_idx)];
      4'h6:    rpt_byte = `GS_CH_SP;
      4'h7,
      4'h8:    rpt_byte = `GS_CH_P;
      4'h9:    rpt_byte = `GS_CH_M;
      4'ha:    rpt_byte = `GS_CH_CR;
      4'hb:    rpt_byte = `GS_CH_LF;
      default: rpt_byte = `GS_CH_SP;
    endcase
  end

  // High time in ms, value clamped to the selected range.
  assign th_calc = 11'(`GS_PWM_START_MS + (`GS_PWM_SPAN_MS * // R9 R11
                   ((32'(conc_i) > PWM_RANGE) ? PWM_RANGE : 32'(conc_i))) / PWM_RANGE);

  // Read frame byte: config, value high, value low, then zeros.
  function automatic logic [7:0] rd_byte(input logic [2:0] i, input logic m,
                                         input logic [15:0] v);
    unique case (i)
      3'h0:    rd_byte = {7'h00, m};
      3'h1:    rd_byte = v[15:8]; // R17
      3'h2:    rd_byte = v[7:0];
      default: rd_byte = `GS_RES_BYTE; // R8
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Serial transmit buffer
  // ---------------------------------------------------------------------------
  assign b_pop = b_valid & ~s_r.tx_busy;

  gs_buf2 u_buf (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (s_r.rp_act),
    .in_data_i   (rpt_byte),
    .in_ready_o  (b_in_ready),
    .out_valid_o (b_valid),
    .out_data_o  (b_data),
    .out_ready_i (~s_r.tx_busy)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic       rise;
    logic       fall;
    logic       i_st;
    logic       i_sp;
    logic       go;
    logic       stop;
    logic [7:0] first;
    rise  = scl_i & ~s_r.scl_q;
    fall  = ~scl_i & s_r.scl_q;
    i_st  = scl_i & s_r.scl_q & s_r.sda_q & ~sda_i;
    i_sp  = scl_i & s_r.scl_q & ~s_r.sda_q & sda_i;
    go    = cal_pin_i & ~s_r.cal_pin_q; // R15
    stop  = 1'b0;
    first = rd_byte(3'h0, s_r.man, s_r.ival);
    n     = s_r;
    n.ms  = 1'b0;
    n.rfr = 1'b0;
    n.scl_q     = scl_i;
    n.sda_q     = sda_i;
    n.cal_pin_q = cal_pin_i;

    // Millisecond enable and five-second refresh.
    if (s_r.div == 18'(MS_CYC - 1))
    begin
      n.div = '0;
      n.ms  = 1'b1;
    end
    else
      n.div = s_r.div + 18'h1;
    if (s_r.ms)
    begin
      if (s_r.rfr_ms == 13'(REFRESH_MS - 1)) // R16
      begin
        n.rfr_ms = '0;
        n.rfr    = 1'b1;
      end
      else
        n.rfr_ms = s_r.rfr_ms + 13'h1;
    end

    // Report bytes enter the buffer while it has room.
    if (s_r.rp_act && b_in_ready)
    begin
      if (s_r.rp_idx == `GS_RPT_LAST)
        n.rp_act = 1'b0;
      else
        n.rp_idx = s_r.rp_idx + 4'h1;
    end

    // Refresh takes a new value and updates the report, PWM high time and alarm.
    if (s_r.rfr)
    begin
      n.val    = conc_i; // R16
      n.th     = th_calc;
      n.rp_act = 1'b1; // R18
      n.rp_idx = '0;
      if (conc_i >= `GS_ALARM_ON_PPM) // R12
        n.alarm = 1'b1;
      else if (conc_i <= `GS_ALARM_OFF_PPM)
        n.alarm = 1'b0;
    end

    // PWM: high while the ms count is below the high time.
    if (s_r.ms)
      n.pms = (s_r.pms == `GS_PWM_PERIOD_MS - 11'h1) ? '0 : s_r.pms + 11'h1; // R10
    n.pwm = (s_r.pms < s_r.th); // R9

    // Serial transmit: start bit, eight data bits LSB first, stop bit.
    if (!s_r.tx_busy)
    begin
      if (b_pop)
      begin
        n.tx_busy = 1'b1;
        n.txd     = 1'b0; // R1
        n.tx_sh   = {1'b1, b_data};
        n.tx_bits = `GS_TX_BITS;
        n.tx_cnt  = 13'(BAUD_CYC - 1);
      end
    end
    else if (s_r.tx_cnt != '0)
      n.tx_cnt = s_r.tx_cnt - 13'h1;
    else if (s_r.tx_bits == '0)
      n.tx_busy = 1'b0;
    else
    begin
      n.txd     = s_r.tx_sh[0];
      n.tx_sh   = {1'b1, s_r.tx_sh[8:1]};
      n.tx_bits = s_r.tx_bits - 4'h1;
      n.tx_cnt  = 13'(BAUD_CYC - 1);
    end

    // Serial receive, sampled at mid-bit; bad start or stop is dropped.
    if (s_r.rx_bit == '0)
    begin
      if (!rxd_i)
      begin
        n.rx_bit = 4'h1;
        n.rx_cnt = 13'(HALF_CYC - 1);
      end
    end
    else if (s_r.rx_cnt != '0)
      n.rx_cnt = s_r.rx_cnt - 13'h1;
    else
    begin
      n.rx_cnt = 13'(BAUD_CYC - 1); // R1
      if (s_r.rx_bit == 4'h1)
        n.rx_bit = rxd_i ? 4'h0 : 4'h2;
      else if (s_r.rx_bit == `GS_RX_STOP)
      begin
        n.rx_bit = '0;
        if (rxd_i && s_r.rx_sh == `GS_CMD_CAL_GO)
          go = 1'b1; // R15
        if (rxd_i && s_r.rx_sh == `GS_CMD_CAL_STOP)
          stop = 1'b1;
      end
      else
      begin
        n.rx_sh  = {rxd_i, s_r.rx_sh[7:1]};
        n.rx_bit = s_r.rx_bit + 4'h1;
      end
    end

    // Two-wire target: bits taken on SCL rise, driven on SCL fall.
    if (i_st)
    begin
      n.ist  = I_ADDR;
      n.icnt = '0;
      n.iack = 1'b0;
      n.ioe  = 1'b0;
    end
    else if (i_sp)
    begin
      n.ist  = I_IDLE;
      n.iack = 1'b0;
      n.ioe  = 1'b0;
    end
    else if (rise)
    begin
      if (s_r.ist == I_RDATA)
      begin
        if (s_r.iack)
        begin
          if (sda_i) // R6
            n.ist = I_IDLE;
          else
          begin
            n.iidx = (s_r.iidx == `GS_RD_LAST) ? s_r.iidx : s_r.iidx + 3'h1;
            n.ish  = rd_byte(n.iidx, s_r.man, s_r.ival);
            n.icnt = '0;
            n.iack = 1'b0;
          end
        end
        else
        begin
          n.ish  = {s_r.ish[6:0], 1'b0};
          n.icnt = s_r.icnt + 4'h1;
        end
      end
      else if (s_r.ist != I_IDLE && !s_r.iack)
      begin
        n.ish  = {s_r.ish[6:0], sda_i};
        n.icnt = s_r.icnt + 4'h1;
      end
    end
    else if (fall)
    begin
      if (s_r.ist == I_RDATA)
      begin
        if (!s_r.iack && s_r.icnt == `GS_BITS)
        begin
          n.ioe  = 1'b0;
          n.iack = 1'b1;
        end
        else if (!s_r.iack)
          n.ioe = ~s_r.ish[7];
      end
      else if (s_r.ist != I_IDLE)
      begin
        if (s_r.iack)
        begin
          n.iack = 1'b0;
          n.ioe  = 1'b0;
          n.icnt = '0;
          if (s_r.ist == I_ADDR && s_r.ird) // R5
          begin
            n.ist  = I_RDATA;
            n.iidx = '0;
            n.ish  = first;
            n.ioe  = ~first[7];
          end
          else
            n.ist = I_WDATA;
        end
        else if (s_r.icnt == `GS_BITS)
        begin
          if (s_r.ist == I_ADDR)
          begin
            if (s_r.ish[7:1] == `GS_I2C_ADDR) // R4
            begin
              n.iack = 1'b1;
              n.ioe  = 1'b1;
              n.ird  = s_r.ish[0];
            end
            else
              n.ist = I_IDLE;
          end
          else
          begin
            n.iack = 1'b1;
            n.ioe  = 1'b1;
            if (s_r.ish == `GS_CMD_READ) // R6
              n.ival = s_r.val;
            if (s_r.ish == `GS_CMD_CAL_GO)
              go = 1'b1; // R15
            if (s_r.ish == `GS_CMD_CAL_STOP)
              stop = 1'b1;
          end
        end
      end
    end

    // Calibration mode: a stop waits until the minimum time has passed.
    if (!s_r.man)
    begin
      if (go)
      begin
        n.man       = 1'b1;
        n.cal_ms    = '0;
        n.stop_pend = 1'b0;
      end
    end
    else
    begin
      if (stop)
        n.stop_pend = 1'b1;
      if (s_r.ms && s_r.cal_ms != 20'(CAL_MS - 1))
        n.cal_ms = s_r.cal_ms + 20'h1;
      if (s_r.cal_ms == 20'(CAL_MS - 1) && (s_r.stop_pend || stop)) // R14
        n.man = 1'b0;
    end
    n.auto = ~n.man; // R13
    n.sdo  = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_r       <= '0;
      s_r.txd   <= 1'b1;
      s_r.auto  <= 1'b1; // R13
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
    end
    else
      s_r <= n;
  end

  // Outputs come straight from state flip-flops.
  assign uart_tx_o                   = s_r.txd;
  assign sda_o                       = s_r.sdo;
  assign sda_oe_o                    = s_r.ioe;
  assign pwm_o                       = s_r.pwm;
  assign alarm_o                     = s_r.alarm;
  assign auto_baseline_calibration_o = s_r.auto;
  assign manual_timed_calibration_o  = s_r.man;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_addr_byte;
    !scl_i && s_r.scl_q && s_r.ist == I_ADDR && !s_r.iack && s_r.icnt == `GS_BITS;
  endsequence

  a_alarm_set: assert property (s_r.rfr && conc_i >= 16'd1200 |=> alarm_o) // R12
    else $error("alarm not set at threshold");
  a_alarm_clear: assert property (s_r.rfr && conc_i <= 16'd800 |=> !alarm_o) // R12
    else $error("alarm not cleared at low threshold");
  a_alarm_hold: assert property (s_r.rfr && conc_i > 16'd800 && conc_i < 16'd1200
    |=> $stable(alarm_o)) // R12
    else $error("alarm changed inside band");
  a_addr_match: assert property (s_addr_byte ##0 s_r.ish[7:1] == 7'h31 |=> sda_oe_o) // R4
    else $error("own address not acknowledged");
  a_addr_other: assert property (s_addr_byte ##0 s_r.ish[7:1] != 7'h31
    |=> s_r.ist == I_IDLE && !sda_oe_o) // R4
    else $error("foreign address answered");
  a_rpt_tail: assert property (s_r.rp_act && b_in_ready && s_r.rp_idx == 4'hb
    |-> rpt_byte == 8'h0a ##1 !s_r.rp_act) // R2
    else $error("report does not end in line feed");
  a_rpt_lead: assert property (s_r.rp_act && s_r.rp_idx == 4'h0 |-> rpt_byte == 8'h20) // R3
    else $error("leading digit not blanked");
  a_tx_start: assert property ($rose(s_r.tx_busy) |-> !uart_tx_o ##1 !uart_tx_o) // R1
    else $error("start bit missing");
  a_cal_min: assert property (manual_timed_calibration_o && s_r.cal_ms != 20'(CAL_MS - 1)
    |=> manual_timed_calibration_o) // R14
    else $error("manual calibration ended early");
  a_cal_excl: assert property (auto_baseline_calibration_o != manual_timed_calibration_o) // R13
    else $error("calibration modes overlap");
  a_pwm_bound: assert property (s_r.pms < 11'd2000 && s_r.th <= 11'd1002) // R10 R9
    else $error("pwm count out of range");
  a_pwm_floor: assert property (s_r.rfr |=> s_r.th >= 11'd2) // R9
    else $error("pwm high time below start portion");
  a_rd_reserved: assert property (s_r.ist == I_RDATA && s_r.iidx >= 3'h3 && s_r.icnt == 4'h0
    |-> s_r.ish == 8'h00) // R8
    else $error("reserved byte not zero");
endmodule // gs_sensor_out

`default_nettype wire

// ==== verification/gs_host.sv ====
// Host model: serial peer and two-wire controller facing the sensor block.
// Assumes the bench clock; the bench resolves the open-drain data wire.
`timescale 1ns/1ps
`default_nettype none

module gs_host #(
  parameter int unsigned BAUD_CYC = 16,
  parameter int unsigned MS_CYC   = 2
)
(
  // Clock.
  input  wire logic mclk_i,
  // Serial link.
  input  wire logic tx_i,
  output var logic  rxd_o,
  // Two-wire bus.
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  logic [7:0] rx_q[$];
  logic [7:0] b;

  // Idle levels: lines released, pull-ups win.
  initial
  begin
    rxd_o = 1'b1;
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Receiver samples mid-bit and keeps only frames with a high stop bit.
  initial
  begin
    forever
    begin
      @(negedge tx_i);
      repeat (BAUD_CYC / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BAUD_CYC) @(posedge mclk_i);
        b[i] = tx_i;
      end
      repeat (BAUD_CYC) @(posedge mclk_i);
      if (tx_i === 1'b1) rx_q.push_back(b);
    end
  end

  // Sends one 8N1 character, LSB first.
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_o = f[i];
      repeat (BAUD_CYC) @(negedge mclk_i);
    end
  endtask

  // One third of a bus bit.
  task automatic half();
    repeat (4) @(negedge mclk_i);
  endtask

  task automatic start();
    sda_low_o = 1'b0;
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
    half();
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask

  // Drives o while the clock is low and samples the wire at the end of high.
  task automatic bit_io(input logic o, output logic i);
    sda_low_o = ~o;
    half();
    scl_o = 1'b1;
    half();
    i = sda_i;
    scl_o = 1'b0;
    half();
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(d[i], x);
    bit_io(1'b1, x);
    ack = ~x;
  endtask

  // Reads one byte after a 1 ms pause; the last byte is not acknowledged.
  task automatic rd(input logic last, output logic [7:0] d);
    logic x;
    repeat (MS_CYC) @(negedge mclk_i);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, x);
      d[i] = x;
    end
    bit_io(last, x);
  endtask
endmodule // gs_host

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench of the gas sensor output block.
// Assumes gs_host is compiled first; 250 MHz clock, shortened timing.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import gs_pkg::*;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  localparam int unsigned MS = 2;
  localparam int unsigned CL = 200;
  logic        mclk, rst_n, cal_pin, tx, rxd, scl, sda_low, sda_o, sda_oe;
  logic        pwm, alarm, auto_cal, man_cal;
  logic [15:0] conc;
  realtime     t_man;
  wire logic   sda;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [7:0]  tail [6] = '{8'h20, 8'h70, 8'h70, 8'h6d, 8'h0d, 8'h0a};
  int          vals [8] = '{1255, 1000, 800, 1199, 1200, 0, 2000, 400};
  logic        als [8] = '{1, 1, 0, 0, 1, 0, 1, 0};

  // Open-drain wire: high unless some party pulls it low.
  assign sda = ~((sda_oe & ~sda_o) | sda_low);

  gs_sensor_out #(.MS_CYC(MS), .BAUD_CYC(16), .REFRESH_MS(1500), .CAL_MS(CL)) i_dut (
    .mclk_i(mclk), .reset_n_i(rst_n), .conc_i(conc), .cal_pin_i(cal_pin), .rxd_i(rxd), .uart_tx_o(tx),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .pwm_o(pwm), .alarm_o(alarm),
    .auto_baseline_calibration_o(auto_cal), .manual_timed_calibration_o(man_cal));

  // The host's default millisecond length already equals MS.
  gs_host #(.BAUD_CYC(16)) i_host (
    .mclk_i(mclk), .tx_i(tx), .rxd_o(rxd), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  // Time at which manual calibration was last seen to start, whatever started it.
  always @(posedge man_cal) t_man = $realtime;

  // Clock of 4 ns.
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // --------------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Sets a value, waits for its twelve-byte report and checks text and alarm.
  task automatic t_report(input int v, input logic al);
    int p;
    logic [7:0] e;
    conc = 16'(v);
    i_host.rx_q.delete();
    for (int i = 0; i < 8000 && i_host.rx_q.size() < 12; i++) @(negedge mclk);
    chk(16'(i_host.rx_q.size()), 16'd12);
    for (int k = 0; k < 12; k++)
    begin
      p = (k < 6) ? 10 ** (5 - k) : 1;
      if (k > 5) e = tail[k - 6];
      else if (v < p && k < 5) e = 8'h20;
      else e = 8'h30 + 8'((v / p) % 10);
      chk({8'h00, i_host.rx_q[k]}, {8'h00, e});
    end
    chk({15'h0000, alarm}, {15'h0000, al});
  endtask

  // Measures one whole PWM period.
  task automatic t_pwm(input int th);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    for (int i = 0; i < 5000 && pwm !== 1'b0; i++) @(negedge mclk);
    for (int i = 0; i < 5000 && pwm !== 1'b1; i++) @(negedge mclk);
    while (pwm === 1'b1 && hi < 5000)
    begin
      hi++;
      @(negedge mclk);
    end
    while (pwm === 1'b0 && lo < 5000)
    begin
      lo++;
      @(negedge mclk);
    end
    chk(16'(hi), 16'(th * MS));
    chk(16'(hi + lo), 16'(2000 * MS));
  endtask

  task automatic t_i2c_cmd(input logic [7:0] c);
    logic a;
    i_host.start();
    i_host.wr(8'h62, a);
    i_host.wr(c, a);
    chk({15'h0000, a}, 16'h0001);
    i_host.stop();
  endtask

  // Wrong address, then command 0x52 and a seven-byte read.
  task automatic t_i2c();
    logic a;
    logic [7:0] d;
    logic [7:0] exp [7];
    exp = '{8'h00, conc[15:8], conc[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
    i_host.start();
    i_host.wr(8'h64, a);
    chk({15'h0000, a}, 16'h0000);
    i_host.stop();
    i_host.start();
    i_host.wr(8'h62, a);
    chk({15'h0000, a}, 16'h0001);
    i_host.wr(8'h52, a);
    chk({15'h0000, a}, 16'h0001);
    i_host.stop();
    i_host.start();
    i_host.wr(8'h63, a);
    chk({15'h0000, a}, 16'h0001);
    for (int k = 0; k < 7; k++)
    begin
      i_host.rd(k == 6, d);
      chk({8'h00, d}, {8'h00, exp[k]});
    end
    i_host.stop();
  endtask

  // Starts manual mode by pin, serial and bus; an early stop is deferred.
  task automatic t_cal();
    int dur;
    for (int m = 0; m < 3; m++)
    begin
      if (m == 0) cal_pin = 1'b1;
      else if (m == 1) i_host.send(8'h4d);
      else t_i2c_cmd(8'h4d);
      for (int i = 0; i < 1000 && man_cal !== 1'b1; i++) @(negedge mclk);
      chk({14'h0000, man_cal, auto_cal}, 16'h0002);
      if (m == 1) t_i2c_cmd(8'h41);
      else i_host.send(8'h41);
      chk({15'h0000, man_cal}, 16'h0001);
      for (int i = 0; i < 1000 && man_cal !== 1'b0; i++) @(negedge mclk);
      dur = int'(($realtime - t_man) / 4.0);
      chk({15'h0000, dur >= (CL - 8) * MS && dur <= (CL + 2) * MS}, 16'h0001);
      chk({14'h0000, man_cal, auto_cal}, 16'h0001);
      cal_pin = 1'b0;
    end
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    cal_pin = 1'b0;
    conc = 16'h0000;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk({10'h000, tx, sda_oe, pwm, alarm, auto_cal, man_cal}, 16'h0022);
    foreach (vals[k]) t_report(vals[k], als[k]);
    t_pwm(202);
    t_i2c();
    t_cal();
    conclude();
  end

  // Cuts a hang short well after the expected run of about 35000 cycles.
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule // tb

`default_nettype wire
